// [include/asp_defines.vh]
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH
// ==========================================
// word and timing constants
`define ASP_WORD_BITS 24
`define ASP_BYTE_BITS 8
`define ASP_CLK_PERIOD_NS 4
`define ASP_SCLK_HALF_NS 80
`define ASP_SCLK_HALF_CYC (`ASP_SCLK_HALF_NS / `ASP_CLK_PERIOD_NS)
// ==========================================
// command codes
`define ASP_CMD_READ_OUT 2'd0
`define ASP_CMD_READ_CTRL 2'd1
`define ASP_CMD_READ_CAL 2'd2
`define ASP_CMD_WRITE 2'd3
`endif

// [tb/adc_serial_host_port_ext_clock_tb_top.sv]
`include "asp_defines.vh"
module adc_serial_host_port_ext_clock_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] CAL = 24'h5a_96c3;
    logic clk_sys = 0, rst_n = 0, clk_en = 1, cmd_valid = 0, cmd_lsb_first = 0, ld = 0;
    logic cal_mode = 0;
    logic [1:0] cmd_op = 0, cmd_bytes = 0;
    logic [23:0] cmd_wdata = 0, ld_word = 0, got, exp_w;
    wire cmd_ready, rsp_valid, rsp_ready_seen, sclk_q, read_frame_n, write_frame_n;
    wire register_select, sdata_o, sdata_oe_n, data_ready_n, sdata_dev;
    wire [23:0] rsp_rdata, ctrl_q;
    wire sdata_i = !sdata_oe_n ? sdata_o : sdata_dev;
    int err_total = 0, cmp_count = 0, seed = 1;
    logic [23:0] out_q[$];
    asp_host #(.HALF_CYC(4)) uut (.*);
    asp_dev_model #(.CAL_INIT(CAL)) dev (.*);
    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;
    function automatic logic [23:0] rev(input logic [23:0] w, input logic on);
        for (int i = 0; i < 24; i++) rev[i] = on ? w[i - 2 * (i % 8) + 7] : w[i];
    endfunction
    task automatic check(input logic [23:0] a, input logic [23:0] b);
        cmp_count++;
        if (a !== b) begin
            err_total++;
            $display("unexpected at %0t ns: got %h want %h", $time, a, b);
        end
    endtask
    task automatic finish_test;
        if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // one command, held until taken; output reads load a word late on purpose
    task automatic run(input logic [1:0] op, nb, input logic lsb, input logic [23:0] w);
        int n;
        got = 'x;
        for (n = 0; cmd_ready !== 1 && n < 999; n++) @(negedge clk_sys);
        @(posedge clk_sys);
        cmd_valid <= 1;
        cmd_op <= op;
        cmd_bytes <= nb;
        cmd_lsb_first <= lsb;
        cmd_wdata <= w;
        @(posedge clk_sys);
        cmd_valid <= 0;
        // freeze the host for a few cycles; the transfer must resume unchanged
        clk_en <= 0;
        repeat (1 + ($random(seed) & 3)) @(posedge clk_sys);
        clk_en <= 1;
        if (op == `ASP_CMD_READ_OUT) begin
            repeat (20) @(negedge clk_sys);
            check(read_frame_n, 1);
            @(posedge clk_sys);
            ld <= 1;
            ld_word <= w;
            out_q.push_back(w);
            @(posedge clk_sys);
            ld <= 0;
        end
        for (n = 0; n < 999 && (n == 0 || cmd_ready !== 1); n++) begin
            @(negedge clk_sys);
            if (rsp_valid === 1) got = rsp_rdata;
        end
    endtask
    initial begin
        logic [23:0] w;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1;
        for (int i = 0; i < 8; i++) begin
            w = 24'($random(seed));
            run(`ASP_CMD_WRITE, 2'(i), i[2], w);
            exp_w = rev(w, i[2]);
            check(ctrl_q, exp_w);
            run(`ASP_CMD_READ_CTRL, 2'(i), i[2], 0);
            check(got, rev(exp_w, i[2]));
            @(posedge clk_sys) cal_mode <= 1;
            run(`ASP_CMD_READ_CAL, 2'(i), i[2], 0);
            check(got, rev(CAL, i[2]));
            @(posedge clk_sys) cal_mode <= 0;
            run(`ASP_CMD_READ_OUT, 2'(i), i[2], 24'($random(seed)));
            check(got, rev(out_q.pop_front(), i[2]));
            check(data_ready_n, 1);
        end
        finish_test;
    end
    // watchdog well beyond the expected run length
    initial begin
        #100000;
        err_total++;
        finish_test;
    end
endmodule // adc_serial_host_port_ext_clock_tb_top

// [tb/asp_dev_model.sv]
// ==========================================
// converter serial port, host-clocked, sampled by the system clock
module asp_dev_model #(parameter logic [23:0] CAL_INIT = 24'h3c_a569) (
    // host pins
    input wire logic clk_sys, sclk_q, read_frame_n, write_frame_n, register_select, sdata_i,
    // bench side
    input wire logic cal_mode, ld,
    input wire logic [23:0] ld_word,
    output logic sdata_dev, data_ready_n,
    output logic [23:0] ctrl_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sclk_d = 0;
    logic frame_d = 1;
    logic [23:0] out_w = 0;
    logic [23:0] sh = 0;
    int ptr = 23;
    int wcnt = 0;
    wire [23:0] word = !register_select ? ctrl_q : (cal_mode ? CAL_INIT : out_w);
    initial begin
        data_ready_n = 1;
        sdata_dev = 0;
        ctrl_q = 0;
    end
    // released line toggles so a stale bit never passes
    always @(posedge clk_sys) begin
        sclk_d <= sclk_q;
        frame_d <= read_frame_n;
        if (ld) begin
            out_w <= ld_word;
            data_ready_n <= 0;
        end
        if (!read_frame_n && (!register_select || cal_mode || !data_ready_n)) begin
            if (frame_d) begin
                sdata_dev <= word[ptr];
            end else if (sclk_d && !sclk_q) begin
                ptr <= (ptr == 0) ? 23 : ptr - 1;
                sdata_dev <= word[(ptr + 23) % 24];
                if (ptr == 0 && register_select && !cal_mode) data_ready_n <= 1;
            end
        end else begin
            sdata_dev <= ~sdata_dev;
        end
        if (!write_frame_n && !sclk_d && sclk_q) begin
            sh = {sh[22:0], sdata_i};
            wcnt = (wcnt == 23) ? 0 : wcnt + 1;
            if (wcnt == 0 && !register_select) ctrl_q <= sh;
        end
    end
endmodule // asp_dev_model

// [tb/asp_host_properties.sv]
`include "asp_defines.vh"
// ==========================================
// host-side timing checks, ports of asp_host only
module asp_host_properties #(parameter HALF_CYC = 20, parameter WORD_BITS = 24) (
    // clock, reset and commands
    input wire clk_sys, rst_n, clk_en, cmd_valid, cmd_lsb_first,
    input wire [1:0] cmd_op, cmd_bytes,
    input wire [WORD_BITS-1:0] cmd_wdata, rsp_rdata,
    // answers and device pins
    input wire cmd_ready, rsp_valid, rsp_ready_seen, sclk_q, read_frame_n,
    input wire write_frame_n, register_select, sdata_o, sdata_oe_n, sdata_i, data_ready_n
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [1:0] op_q;
    reg sclk_p;
    int bit_q;
    int hi_q;
    // rising serial clock edges since the take, and length of the high phase
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            op_q <= 0;
            sclk_p <= 0;
            bit_q <= 0;
            hi_q <= 0;
        end else if (clk_en) begin
            sclk_p <= sclk_q;
            hi_q <= sclk_q ? hi_q + 1 : 0;
            if (cmd_valid && cmd_ready) begin
                op_q <= cmd_op;
                bit_q <= 0;
            end else if (sclk_q && !sclk_p) begin
                bit_q <= bit_q + 1;
            end
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // a strobe returning high ends a byte or the word
    sequence frame_up_s;
        $rose(read_frame_n) || $rose(write_frame_n);
    endsequence
    one_strobe_a: assert property (read_frame_n || write_frame_n)
        else $error("both strobes low");
    idle_pins_a: assert property (cmd_ready |-> read_frame_n && write_frame_n && !sclk_q)
        else $error("pins not idle");
    ctrl_sel_a: assert property (!read_frame_n && op_q == 1 |-> !register_select)
        else $error("control read with select high");
    data_sel_a: assert property (!read_frame_n && op_q != 1 |-> register_select)
        else $error("data read with select low");
    write_sel_a: assert property (!write_frame_n |-> !register_select && !sdata_oe_n)
        else $error("write not to control register");
    ready_gate_a: assert property ($fell(read_frame_n) && op_q == 0 |-> rsp_ready_seen)
        else $error("output read before data ready");
    half_period_a: assert property ($fell(sclk_q) |-> hi_q == HALF_CYC)
        else $error("serial clock high phase wrong");
    byte_split_a: assert property (frame_up_s |-> !sclk_q && bit_q % 8 == 0 && bit_q != 0)
        else $error("strobe rose off a byte boundary");
    word_len_a: assert property (rsp_valid |-> bit_q == WORD_BITS ##1 !rsp_valid)
        else $error("word length wrong");
endmodule // asp_host_properties
bind asp_host asp_host_properties #(.HALF_CYC(HALF_CYC), .WORD_BITS(WORD_BITS)) u_props (.*);

// [verilog/asp_bitrev.v]
`include "asp_defines.vh"
// ==========================================
// byte-wise bit order reversal for lsb-first host ports
module asp_bitrev #(
    parameter N = 24
) (
    // data
    input wire [N-1:0] din,
    input wire enable,
    output reg [N-1:0] dout
);
    integer i;
    // swap bit order inside each byte so lsb-first ports see msb-first order
    always @* begin
        dout = din;
        if (enable) begin
            for (i = 0; i < N; i = i + 1) begin
                dout[i] = din[(i / 8) * 8 + 7 - (i % 8)];
            end
        end
    end
endmodule // asp_bitrev

// [verilog/asp_host.v]
`include "asp_defines.vh"
// ==========================================
// host end of the converter serial port, host supplies the serial clock
module asp_host #(
    parameter HALF_CYC = `ASP_SCLK_HALF_CYC,
    parameter WORD_BITS = `ASP_WORD_BITS
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    // command port
    input wire cmd_valid,
    input wire [1:0] cmd_op,
    input wire [1:0] cmd_bytes,
    input wire cmd_lsb_first,
    input wire [WORD_BITS-1:0] cmd_wdata,
    output reg cmd_ready,
    output reg rsp_valid,
    output reg [WORD_BITS-1:0] rsp_rdata,
    output reg rsp_ready_seen,
    // device pins
    output reg sclk_q,
    output reg read_frame_n,
    output reg write_frame_n,
    output reg register_select,
    output reg sdata_o,
    output reg sdata_oe_n,
    input wire sdata_i,
    input wire data_ready_n
);
    localparam ST_IDLE = 3'd0;
    localparam ST_WAIT = 3'd1;
    localparam ST_LOW = 3'd2;
    localparam ST_HIGH = 3'd3;
    localparam ST_GAP = 3'd4;
    localparam ST_DONE = 3'd5;
    localparam [7:0] HALF = HALF_CYC;

    // ==========================================
    // pin synchronisers
    reg sdi_m_q, sdi_q, rdy_m_q, rdy_q;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sdi_m_q <= 1'b0;
            sdi_q <= 1'b0;
            rdy_m_q <= 1'b1;
            rdy_q <= 1'b1;
        end else if (clk_en) begin
            sdi_m_q <= sdata_i;
            sdi_q <= sdi_m_q;
            rdy_m_q <= data_ready_n;
            rdy_q <= rdy_m_q;
        end
    end

    // ==========================================
    // bit order handling within each byte
    wire [WORD_BITS-1:0] wdata_msb;
    wire [WORD_BITS-1:0] sh_rev;
    reg [WORD_BITS-1:0] sh_q;
    reg lsb_q;
    asp_bitrev #(.N(WORD_BITS)) u_wrev (
        .din(cmd_wdata),
        .enable(cmd_lsb_first),
        .dout(wdata_msb)
    );
    asp_bitrev #(.N(WORD_BITS)) u_rrev (
        .din(sh_q),
        .enable(lsb_q),
        .dout(sh_rev)
    );

    // ==========================================
    // transfer sequencer
    reg [2:0] st_q;
    reg [1:0] op_q;
    reg [7:0] tick_q;
    reg [4:0] bit_q;
    reg [2:0] inbyte_q;
    reg [1:0] bpo_q;
    wire tick_done = (tick_q == HALF - 8'd1);
    wire is_wr = (op_q == `ASP_CMD_WRITE);

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            op_q <= 2'd0;
            tick_q <= 8'd0;
            bit_q <= 5'd0;
            inbyte_q <= 3'd0;
            bpo_q <= 2'd3;
            lsb_q <= 1'b0;
            sh_q <= {WORD_BITS{1'b0}};
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= {WORD_BITS{1'b0}};
            rsp_ready_seen <= 1'b0;
            sclk_q <= 1'b0;
            read_frame_n <= 1'b1;
            write_frame_n <= 1'b1;
            register_select <= 1'b1;
            sdata_o <= 1'b0;
            sdata_oe_n <= 1'b1;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            rsp_ready_seen <= ~rdy_q;
            tick_q <= tick_done ? 8'd0 : tick_q + 8'd1;
            case (st_q)
                ST_IDLE: begin
                    cmd_ready <= 1'b1;
                    sclk_q <= 1'b0;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        op_q <= cmd_op;
                        lsb_q <= cmd_lsb_first;
                        sh_q <= wdata_msb; // msb first on the wire
                        bpo_q <= (cmd_bytes == 2'd0) ? 2'd3 : cmd_bytes;
                        bit_q <= 5'd0;
                        inbyte_q <= 3'd0;
                        tick_q <= 8'd0;
                        st_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // output reads hold off until data-ready is low; others ignore it
                    if (op_q != `ASP_CMD_READ_OUT || !rdy_q) begin
                        // control read uses select low with the read strobe
                        // writes always land in the control register
                        register_select <= (op_q == `ASP_CMD_READ_CTRL) ? 1'b0 :
                            (op_q == `ASP_CMD_WRITE) ? 1'b0 : 1'b1;
                        if (is_wr) begin
                            write_frame_n <= 1'b0; // only one strobe low
                            sdata_oe_n <= 1'b0;
                            sdata_o <= sh_q[WORD_BITS-1];
                        end else begin
                            read_frame_n <= 1'b0;
                        end
                        tick_q <= 8'd0;
                        st_q <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (tick_done) begin
                        sclk_q <= 1'b1; // device samples write data while high
                        if (!is_wr) begin
                            // read bit valid before the rising edge
                            sh_q <= {sh_q[WORD_BITS-2:0], sdi_q};
                        end
                        st_q <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (tick_done) begin
                        sclk_q <= 1'b0;
                        if (is_wr) begin
                            sh_q <= {sh_q[WORD_BITS-2:0], 1'b0};
                            sdata_o <= sh_q[WORD_BITS-2];
                        end
                        bit_q <= bit_q + 5'd1;
                        inbyte_q <= inbyte_q + 3'd1;
                        if (bit_q == WORD_BITS - 1) begin
                            st_q <= ST_DONE;
                        end else if (inbyte_q == 3'd7 && bpo_q != 2'd1) begin
                            st_q <= ST_GAP; // strobe rises during sclk low
                        end else begin
                            st_q <= ST_LOW;
                        end
                    end
                end
                ST_GAP: begin
                    // strobe high for one cycle less than a half period between byte operations
                    if (tick_done) begin
                        if (read_frame_n && write_frame_n) begin
                            if (is_wr) begin
                                write_frame_n <= 1'b0;
                            end else begin
                                read_frame_n <= 1'b0;
                            end
                            st_q <= ST_LOW;
                        end
                    end else if (tick_q == 8'd0) begin
                        read_frame_n <= 1'b1;
                        write_frame_n <= 1'b1;
                        inbyte_q <= 3'd0;
                    end
                end
                ST_DONE: begin
                    // raise strobe after 24 bits and restore idle levels in the same cycle
                    read_frame_n <= 1'b1;
                    write_frame_n <= 1'b1;
                    register_select <= 1'b1;
                    sdata_oe_n <= 1'b1;
                    sdata_o <= 1'b0;
                    rsp_valid <= ~is_wr;
                    rsp_rdata <= sh_rev;
                    st_q <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // asp_host
